// *** src/sre_pkg.sv ***
// Shared constants and types of the serial EEPROM read engine
//
// Functional notes
// R1 - Read opens like write, direction bit high
// R2 - Current, random and sequential reads supported
// R3 - Pointer holds last accessed word plus one
// R4 - Read address acked, then eight data bits
// R5 - Master nacks then stops; memory releases line
// R6 - Word address write, repeated start keeps pointer
// R7 - Control byte resent for read, then data
// R8 - Master ack requests the next sequential word
// R9 - Pointer advances by one per word
// R10 - Low supply blocks internal write logic
// R11 - Pointer wraps past top to zero
// R12 - Line released after byte for ack sampling
package sre_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int DW = 8;
   localparam int AW = 7;
   localparam int MEM_DEPTH = 2 ** AW;
   localparam int LEN_W = 8;
   localparam int CNT_W = 4;

   // ****************************************
   // Bus encoding
   // ****************************************
   // Bus address of the memory, value arbitrary
   localparam logic [6:0] DEV_ADDR_DEF = 7'h2c;
   localparam int RW_BIT = 0;
   localparam logic DIR_RD = 1'b1;
   localparam logic DIR_WR = 1'b0;
   localparam logic ACK_LVL = 1'b0;
   localparam logic REL_LVL = 1'b1;
   localparam logic [CNT_W-1:0] BYTE_BITS = 4'h8;
   localparam logic [DW-1:0] RX_FILL = 8'hff;

   // ****************************************
   // Link timing
   // ****************************************
   localparam int QTR_CYC = 64;
   localparam logic [1:0] Q_LAST = 2'h3;
   localparam logic [1:0] Q_DRIVE = 2'h1;
   localparam logic [1:0] Q_RISE = 2'h2;

   // ****************************************
   // Enumerations
   // ****************************************
   typedef enum logic [1:0] {
      OP_CUR = 2'h0,
      OP_RAND = 2'h1,
      OP_WR = 2'h2
   } sre_op_type;

   typedef enum logic [2:0] {
      D_IDLE = 3'h0,
      D_ADR = 3'h1,
      D_AA = 3'h3,
      D_WA = 3'h2,
      D_WK = 3'h6,
      D_WD = 3'h7,
      D_RD = 3'h5,
      D_RK = 3'h4
   } sre_dst_type;

   typedef enum logic [1:0] {
      M_IDLE = 2'h0,
      M_START = 2'h1,
      M_BIT = 2'h3,
      M_STOP = 2'h2
   } sre_mst_type;

   typedef enum logic [2:0] {
      P_CW = 3'h0,
      P_WA = 3'h1,
      P_WD = 3'h3,
      P_CR = 3'h2,
      P_RD = 3'h6
   } sre_ph_type;

endpackage : sre_pkg

// *** src/sre_link_if.sv ***
// Two-wire link between bus master and serial memory
`timescale 1ns/100ps
interface sre_link_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic sda;

   // Open-drain data line with pull-up
   assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

   modport master (output scl, output m_sda_o, output m_sda_oe,
                   input sda);
   modport device (input scl, input sda, output d_sda_o,
                   output d_sda_oe);
endinterface : sre_link_if

// *** src/sre_sync.sv ***
// Two-stage synchroniser for levels
`timescale 1ns/100ps
module sre_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Destination clock
   input wire logic clk_i,
   input wire logic rst_i,
   // Levels
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // First stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= INIT;
         q_ff <= INIT;
      end else begin
         meta_ff <= d_i;
         q_ff <= meta_ff;
      end
   end

   assign q_o = q_ff;
endmodule : sre_sync

// *** src/sre_host.sv ***
// Bus master end: builds reads and writes on the link
`timescale 1ns/100ps
module sre_host #(
   parameter int QTR = sre_pkg::QTR_CYC,
   parameter logic [6:0] DEV_ADDR = sre_pkg::DEV_ADDR_DEF
) (
   // System
   input wire logic clk_i,
   input wire logic srst_i,
   // Requests
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire sre_pkg::sre_op_type req_op_i,
   input wire logic [sre_pkg::AW-1:0] req_addr_i,
   input wire logic [sre_pkg::DW-1:0] req_data_i,
   input wire logic [sre_pkg::LEN_W-1:0] req_len_i,
   // Answers
   output logic [sre_pkg::DW-1:0] rd_data_o,
   output logic rd_valid_o,
   output logic done_o,
   output logic err_o,
   // Link
   sre_link_if.master link
);
   localparam int TW = $clog2(QTR);
   localparam int FW = sre_pkg::DW + 1;
   localparam int LW = sre_pkg::LEN_W;

   sre_pkg::sre_mst_type st_ff, nxt_st;
   sre_pkg::sre_ph_type ph_ff, nxt_ph;
   sre_pkg::sre_op_type op_ff, nxt_op;
   logic [1:0] q_ff, nxt_q;
   logic [TW-1:0] tick_ff, nxt_tick;
   logic [sre_pkg::CNT_W-1:0] bit_ff, nxt_bit;
   logic [FW-1:0] tx_ff, nxt_tx, rx_ff, nxt_rx;
   logic [sre_pkg::LEN_W-1:0] rem_ff, nxt_rem;
   logic [sre_pkg::AW-1:0] adr_ff, nxt_adr;
   logic [sre_pkg::DW-1:0] wd_ff, nxt_wd, rdat_ff, nxt_rdat;
   logic oe_ff, nxt_oe, scl_ff, nxt_scl;
   logic rval_ff, nxt_rval, done_ff, nxt_done, err_ff, nxt_err;
   logic sda_s;
   logic tick_end;

   // Read frame: released data bits, then ack or nack
   function automatic logic [FW-1:0] rd_frame(
      input logic [sre_pkg::LEN_W-1:0] left);
      rd_frame = {sre_pkg::RX_FILL,
                  (left > 1) ? sre_pkg::ACK_LVL : sre_pkg::REL_LVL}; // R8
   endfunction : rd_frame

   sre_sync #(.W(1), .INIT(1'b1)) u_sda_sync (
      .clk_i(clk_i),
      .rst_i(srst_i),
      .d_i(link.sda),
      .q_o(sda_s)
   );

   assign tick_end = (tick_ff == TW'(QTR - 1));

   // Link sequencer, one quarter of a bit per QTR clock cycles
   always_comb begin
      nxt_st = st_ff;
      nxt_ph = ph_ff;
      nxt_op = op_ff;
      nxt_q = q_ff;
      nxt_tick = tick_end ? '0 : TW'(tick_ff + 1'b1);
      nxt_bit = bit_ff;
      nxt_tx = tx_ff;
      nxt_rx = rx_ff;
      nxt_rem = rem_ff;
      nxt_adr = adr_ff;
      nxt_wd = wd_ff;
      nxt_rdat = rdat_ff;
      nxt_oe = oe_ff;
      nxt_scl = scl_ff;
      nxt_rval = 1'b0;
      nxt_done = 1'b0;
      nxt_err = err_ff;
      case (st_ff)
         sre_pkg::M_IDLE: begin
            nxt_tick = '0;
            nxt_q = '0;
            nxt_scl = 1'b1;
            nxt_oe = 1'b0;
            if (req_valid_i) begin
               nxt_op = req_op_i;
               nxt_adr = req_addr_i;
               nxt_wd = req_data_i;
               nxt_rem = (req_len_i == '0) ? LW'(1) : req_len_i;
               nxt_ph = (req_op_i == sre_pkg::OP_CUR) ?
                        sre_pkg::P_CR : sre_pkg::P_CW;
               nxt_err = 1'b0;
               nxt_st = sre_pkg::M_START;
            end
         end
         default: begin
            if (tick_end) begin
               nxt_q = 2'(q_ff + 1'b1);
               nxt_scl = nxt_q[1];
               if (nxt_q == sre_pkg::Q_DRIVE) begin
                  case (st_ff)
                     sre_pkg::M_BIT: nxt_oe = ~tx_ff[FW-1];
                     sre_pkg::M_STOP: nxt_oe = 1'b1;
                     default: nxt_oe = 1'b0;
                  endcase
               end
               // Start: data falls while clock is high
               if (nxt_q == sre_pkg::Q_LAST && st_ff == sre_pkg::M_START)
                  nxt_oe = 1'b1;
               // Stop: data rises while clock is high
               if (nxt_q == sre_pkg::Q_LAST && st_ff == sre_pkg::M_STOP)
                  nxt_oe = 1'b0;
               if (q_ff == sre_pkg::Q_LAST) begin
                  case (st_ff)
                     sre_pkg::M_START: begin
                        nxt_st = sre_pkg::M_BIT;
                        nxt_bit = '0;
                        nxt_tx = {DEV_ADDR,
                                  (ph_ff == sre_pkg::P_CR) ?
                                  sre_pkg::DIR_RD : sre_pkg::DIR_WR, // R1
                                  sre_pkg::REL_LVL};
                     end
                     sre_pkg::M_STOP: begin
                        nxt_st = sre_pkg::M_IDLE;
                        nxt_done = 1'b1;
                     end
                     default: begin
                        nxt_rx = {rx_ff[FW-2:0], sda_s};
                        nxt_tx = {tx_ff[FW-2:0], sre_pkg::REL_LVL};
                        nxt_bit = 4'(bit_ff + 1'b1);
                        if (bit_ff == sre_pkg::BYTE_BITS) begin
                           nxt_bit = '0;
                           if (ph_ff != sre_pkg::P_RD &&
                               sda_s != sre_pkg::ACK_LVL) begin
                              nxt_err = 1'b1;
                              nxt_st = sre_pkg::M_STOP;
                           end else begin
                              case (ph_ff)
                                 sre_pkg::P_CW: begin
                                    nxt_ph = sre_pkg::P_WA;
                                    nxt_tx = {1'b0, adr_ff,
                                              sre_pkg::REL_LVL};
                                 end
                                 sre_pkg::P_WA: begin
                                    if (op_ff == sre_pkg::OP_WR) begin
                                       nxt_ph = sre_pkg::P_WD;
                                       nxt_tx = {wd_ff, sre_pkg::REL_LVL};
                                    end else begin
                                       nxt_ph = sre_pkg::P_CR; // R6
                                       nxt_st = sre_pkg::M_START;
                                    end
                                 end
                                 sre_pkg::P_CR: begin
                                    nxt_ph = sre_pkg::P_RD; // R7
                                    nxt_tx = rd_frame(rem_ff);
                                 end
                                 sre_pkg::P_RD: begin
                                    nxt_rdat = nxt_rx[FW-1:1];
                                    nxt_rval = 1'b1;
                                    if (rem_ff > 1) begin
                                       nxt_rem = LW'(rem_ff - 1'b1);
                                       nxt_tx = rd_frame(nxt_rem);
                                    end else begin
                                       nxt_st = sre_pkg::M_STOP; // R5
                                    end
                                 end
                                 default: nxt_st = sre_pkg::M_STOP;
                              endcase
                           end
                        end
                     end
                  endcase
               end
            end
         end
      endcase
   end

   // Register the sequencer
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_ff <= sre_pkg::M_IDLE;
         ph_ff <= sre_pkg::P_CW;
         op_ff <= sre_pkg::OP_CUR;
         q_ff <= '0;
         tick_ff <= '0;
         bit_ff <= '0;
         tx_ff <= '0;
         rx_ff <= '0;
         rem_ff <= '0;
         adr_ff <= '0;
         wd_ff <= '0;
         rdat_ff <= '0;
         oe_ff <= 1'b0;
         scl_ff <= 1'b1;
         rval_ff <= 1'b0;
         done_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         ph_ff <= nxt_ph;
         op_ff <= nxt_op;
         q_ff <= nxt_q;
         tick_ff <= nxt_tick;
         bit_ff <= nxt_bit;
         tx_ff <= nxt_tx;
         rx_ff <= nxt_rx;
         rem_ff <= nxt_rem;
         adr_ff <= nxt_adr;
         wd_ff <= nxt_wd;
         rdat_ff <= nxt_rdat;
         oe_ff <= nxt_oe;
         scl_ff <= nxt_scl;
         rval_ff <= nxt_rval;
         done_ff <= nxt_done;
         err_ff <= nxt_err;
      end
   end

   // Outputs
   assign req_ready_o = (st_ff == sre_pkg::M_IDLE);
   assign rd_data_o = rdat_ff;
   assign rd_valid_o = rval_ff;
   assign done_o = done_ff;
   assign err_o = err_ff;
   assign link.scl = scl_ff;
   assign link.m_sda_o = 1'b0;
   assign link.m_sda_oe = oe_ff;
endmodule : sre_host

// *** src/sre_mem_dev.sv ***
// Serial data memory end: two-wire slave with word array
`timescale 1ns/100ps
module sre_mem_dev #(
   parameter logic [6:0] DEV_ADDR = sre_pkg::DEV_ADDR_DEF,
   parameter int DEPTH = sre_pkg::MEM_DEPTH
) (
   // System side
   input wire logic clk_i,
   input wire logic srst_i,
   output logic busy_o,
   output logic inhibit_o,
   // Supply threshold detector, high while supply is good
   input wire logic supply_ok_i,
   // Link side
   input wire logic link_clk_i,
   sre_link_if.device link
);
   localparam int DW = sre_pkg::DW;
   localparam int AW = sre_pkg::AW;

   // ****************************************
   // Link domain state
   // ****************************************
   sre_pkg::sre_dst_type st_ff, nxt_st;
   logic [sre_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [DW-1:0] sh_ff, nxt_sh;
   logic [AW-1:0] ptr_ff, nxt_ptr;
   logic rw_ff, nxt_rw;
   logic oe_ff, nxt_oe;
   logic scl_p_ff, sda_p_ff;
   logic busy_ff, nxt_busy;
   logic [DW-1:0] mem_ff [DEPTH];

   logic lrst;
   logic scl_s, sda_s, inh_s;
   logic rise, fall, start, stop;
   logic we, load;
   logic [DW-1:0] rd_word;

   // Next pointer value, wraps at the top of the array
   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = AW'(p + 1'b1); // R11
   endfunction : ptr_inc

   // ****************************************
   // Crossings
   // ****************************************
   // Reset carried into the link domain
   sre_sync #(.W(1), .INIT(1'b1)) u_rst_sync (
      .clk_i(link_clk_i),
      .rst_i(1'b0),
      .d_i(srst_i),
      .q_o(lrst)
   );

   // Bus pins and supply level into the link domain
   sre_sync #(.W(3), .INIT(3'b110)) u_pin_sync (
      .clk_i(link_clk_i),
      .rst_i(lrst),
      .d_i({link.scl, link.sda, ~supply_ok_i}),
      .q_o({scl_s, sda_s, inh_s})
   );

   // Status levels into the system domain
   sre_sync #(.W(2), .INIT(2'b00)) u_sts_sync (
      .clk_i(clk_i),
      .rst_i(srst_i),
      .d_i({busy_ff, ~supply_ok_i}),
      .q_o({busy_o, inhibit_o})
   );

   // ****************************************
   // Bus event detection
   // ****************************************
   assign rise = scl_s & ~scl_p_ff;
   assign fall = ~scl_s & scl_p_ff;
   // Data edges while clock stays high frame a transaction
   assign start = scl_s & scl_p_ff & sda_p_ff & ~sda_s;
   assign stop = scl_s & scl_p_ff & ~sda_p_ff & sda_s;

   assign rd_word = mem_ff[ptr_ff];

   // ****************************************
   // Slave protocol
   // ****************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_sh = sh_ff;
      nxt_ptr = ptr_ff;
      nxt_rw = rw_ff;
      nxt_oe = oe_ff;
      we = 1'b0;
      load = 1'b0;
      if (start) begin
         // Plain or repeated start, pointer untouched
         nxt_st = sre_pkg::D_ADR; // R6
         nxt_cnt = '0;
         nxt_oe = 1'b0;
      end else if (stop) begin
         nxt_st = sre_pkg::D_IDLE;
         nxt_oe = 1'b0; // R5
      end else begin
         case (st_ff)
            sre_pkg::D_ADR, sre_pkg::D_WA, sre_pkg::D_WD: begin
               // Shift in one byte on rising clock edges
               if (rise && cnt_ff != sre_pkg::BYTE_BITS) begin
                  nxt_sh = {sh_ff[DW-2:0], sda_s};
                  nxt_cnt = 4'(cnt_ff + 1'b1);
               end
               if (fall && cnt_ff == sre_pkg::BYTE_BITS) begin
                  nxt_oe = 1'b1;
                  nxt_st = sre_pkg::D_WK;
                  if (st_ff == sre_pkg::D_ADR) begin
                     if (sh_ff[DW-1:1] == DEV_ADDR) begin
                        nxt_st = sre_pkg::D_AA; // R4
                        nxt_rw = sh_ff[sre_pkg::RW_BIT]; // R1
                     end else begin
                        nxt_oe = 1'b0;
                        nxt_st = sre_pkg::D_IDLE;
                     end
                  end else if (st_ff == sre_pkg::D_WA) begin
                     nxt_ptr = sh_ff[AW-1:0]; // R6
                  end else begin
                     we = ~inh_s; // R10
                     nxt_ptr = ptr_inc(ptr_ff); // R3
                  end
               end
            end
            sre_pkg::D_AA: begin
               // Address ack ends; read or take word address
               if (fall) begin
                  if (rw_ff == sre_pkg::DIR_RD) begin
                     load = 1'b1; // R2
                  end else begin
                     nxt_oe = 1'b0;
                     nxt_st = sre_pkg::D_WA;
                     nxt_cnt = '0;
                  end
               end
            end
            sre_pkg::D_WK: begin
               if (fall) begin
                  nxt_oe = 1'b0;
                  nxt_st = sre_pkg::D_WD;
                  nxt_cnt = '0;
               end
            end
            sre_pkg::D_RD: begin
               // Shift out on falling edges, release after last bit
               if (fall) begin
                  if (cnt_ff == sre_pkg::BYTE_BITS) begin
                     nxt_oe = 1'b0; // R12
                     nxt_st = sre_pkg::D_RK;
                  end else begin
                     nxt_oe = ~sh_ff[DW-1];
                     nxt_sh = {sh_ff[DW-2:0], 1'b0};
                     nxt_cnt = 4'(cnt_ff + 1'b1);
                  end
               end
            end
            sre_pkg::D_RK: begin
               // Master ack asks for more, nack ends the read
               if (rise) begin
                  if (sda_s == sre_pkg::ACK_LVL)
                     nxt_cnt = '0; // R8
                  else
                     nxt_st = sre_pkg::D_IDLE; // R5
               end
               if (fall && cnt_ff == '0)
                  load = 1'b1; // R8
            end
            default: nxt_st = sre_pkg::D_IDLE;
         endcase
         // Fetch word at pointer and drive its top bit
         if (load) begin
            nxt_sh = {rd_word[DW-2:0], 1'b0};
            nxt_oe = ~rd_word[DW-1]; // R4
            nxt_cnt = 4'h1;
            nxt_ptr = ptr_inc(ptr_ff); // R9
            nxt_st = sre_pkg::D_RD;
         end
      end
      nxt_busy = (nxt_st != sre_pkg::D_IDLE);
   end

   // Register link domain state
   always_ff @(posedge link_clk_i) begin
      if (lrst) begin
         st_ff <= sre_pkg::D_IDLE;
         cnt_ff <= '0;
         sh_ff <= '0;
         ptr_ff <= '0;
         rw_ff <= 1'b0;
         oe_ff <= 1'b0;
         scl_p_ff <= 1'b1;
         sda_p_ff <= 1'b1;
         busy_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         sh_ff <= nxt_sh;
         ptr_ff <= nxt_ptr;
         rw_ff <= nxt_rw;
         oe_ff <= nxt_oe;
         scl_p_ff <= scl_s;
         sda_p_ff <= sda_s;
         busy_ff <= nxt_busy;
      end
   end

   // Word array, written only with supply good
   always_ff @(posedge link_clk_i) begin
      if (we)
         mem_ff[ptr_ff] <= sh_ff; // R10
   end

   // Open-drain data: enable pulls the line low
   assign link.d_sda_o = 1'b0;
   assign link.d_sda_oe = oe_ff;
endmodule : sre_mem_dev

// *** tb/sre_link_properties.sv ***
// Concurrent checks on the two-wire link between master and memory
`timescale 1ns/100ps
module sre_link_properties (
   // System
   input wire logic clk_i,
   input wire logic srst_i,
   // Link signals
   input wire logic scl,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic d_sda_o,
   input wire logic d_sda_oe,
   input wire logic sda
);
   // ****************************************
   // Frame tracking
   // ****************************************
   logic [3:0] bitn_ff;
   logic [3:0] nxt_bitn;
   logic scl_ff, sda_ff, first_ff, rd_ff;
   logic nxt_first, nxt_rd;
   logic start_w, stop_w, rise_w, fall_w, dbit_w;

   // Line events seen on the system clock
   assign start_w = scl & scl_ff & sda_ff & ~sda;
   assign stop_w = scl & scl_ff & ~sda_ff & sda;
   assign rise_w = scl & ~scl_ff;
   assign fall_w = ~scl & scl_ff;
   assign dbit_w = (bitn_ff != 4'h0) && (bitn_ff != 4'h9);

   // Bit count, first byte flag and direction
   always_comb begin
      nxt_bitn = bitn_ff;
      nxt_first = first_ff;
      nxt_rd = rd_ff;
      if (start_w) begin
         nxt_bitn = 4'h0;
         nxt_first = 1'b1;
      end else if (stop_w) begin
         nxt_bitn = 4'h0;
      end else if (rise_w) begin
         nxt_bitn = (bitn_ff == 4'h9) ? 4'h1 : bitn_ff + 4'h1;
      end
      if (fall_w && first_ff && bitn_ff == 4'h8) begin
         nxt_rd = sda;
      end
      if (fall_w && bitn_ff == 4'h9) begin
         nxt_first = 1'b0;
      end
   end

   // Tracking registers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
         bitn_ff <= 4'h0;
         first_ff <= 1'b0;
         rd_ff <= 1'b0;
      end else begin
         scl_ff <= scl;
         sda_ff <= sda;
         bitn_ff <= nxt_bitn;
         first_ff <= nxt_first;
         rd_ff <= nxt_rd;
      end
   end

   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   sequence s_stop;
      stop_w;
   endsequence
   sequence s_quiet;
      !d_sda_oe [*8];
   endsequence

   property p_open_drain;
      !m_sda_o && !d_sda_o && ((m_sda_oe || d_sda_oe) == !sda);
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("link end drove the data line high");

   property p_start_by_master;
      start_w |-> m_sda_oe && !d_sda_oe;
   endproperty
   a_start_by_master: assert property (p_start_by_master)
      else $error("start not made by the master alone");

   property p_dev_edge;
      $changed(d_sda_oe) |-> !scl;
   endproperty
   a_dev_edge: assert property (p_dev_edge)
      else $error("memory changed data while clock high");

   property p_stop_quiet;
      s_stop |=> s_quiet;
   endproperty
   a_stop_quiet: assert property (p_stop_quiet)
      else $error("memory drove the line after stop");

   property p_stop_scl;
      stop_w |-> $past(scl, 8);
   endproperty
   a_stop_scl: assert property (p_stop_scl)
      else $error("stop without clock held high");

   property p_addr_ack;
      fall_w && first_ff && bitn_ff == 4'h9 |-> d_sda_oe;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("control byte not acknowledged");

   property p_rd_release;
      fall_w && !first_ff && rd_ff && bitn_ff == 4'h9 |-> !d_sda_oe;
   endproperty
   a_rd_release: assert property (p_rd_release)
      else $error("memory held the line in the ack slot");

   property p_ack_slot_free;
      rise_w && !first_ff && rd_ff && bitn_ff == 4'h8 |-> !d_sda_oe;
   endproperty
   a_ack_slot_free: assert property (p_ack_slot_free)
      else $error("memory drove the line when ack was sampled");

   property p_rd_master_off;
      fall_w && !first_ff && rd_ff && dbit_w |-> !m_sda_oe;
   endproperty
   a_rd_master_off: assert property (p_rd_master_off)
      else $error("master drove the line during read data");

   property p_wr_dev_off;
      fall_w && !first_ff && !rd_ff && dbit_w |-> !d_sda_oe;
   endproperty
   a_wr_dev_off: assert property (p_wr_dev_off)
      else $error("memory drove the line during write data");
endmodule : sre_link_properties

// *** tb/serial_eeprom_read_engine_test.sv ***
// Testbench joining the bus master and the serial memory
`timescale 1ns/100ps
module serial_eeprom_read_engine_test;
   // ****************************************
   // Signals
   // ****************************************
   logic clk_i = 1'b0;
   logic link_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic req_valid_i = 1'b0;
   sre_pkg::sre_op_type req_op_i = sre_pkg::OP_CUR;
   logic [sre_pkg::AW-1:0] req_addr_i = '0;
   logic [sre_pkg::DW-1:0] req_data_i = '0;
   logic [sre_pkg::LEN_W-1:0] req_len_i = '0;
   logic supply_ok_i = 1'b1;
   logic req_ready_o, rd_valid_o, done_o, err_o, busy_o, inhibit_o;
   logic [sre_pkg::DW-1:0] rd_data_o;
   logic [sre_pkg::DW-1:0] rxq[$];
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;

   sre_link_if link_if ();

   // System clock, 8 ns
   always #4 clk_i = ~clk_i;
   // Link clock, 80 ns, offset phase
   initial begin
      #3;
      forever #40 link_clk_i = ~link_clk_i;
   end

   // ****************************************
   // Design and checker
   // ****************************************
   sre_host sre_host_inst (.clk_i(clk_i), .srst_i(srst_i),
      .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
      .req_op_i(req_op_i), .req_addr_i(req_addr_i),
      .req_data_i(req_data_i), .req_len_i(req_len_i),
      .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .done_o(done_o),
      .err_o(err_o), .link(link_if));
   sre_mem_dev sre_mem_dev_inst (.clk_i(clk_i), .srst_i(srst_i),
      .busy_o(busy_o), .inhibit_o(inhibit_o), .supply_ok_i(supply_ok_i),
      .link_clk_i(link_clk_i), .link(link_if));
   sre_link_properties sre_link_properties_inst (.clk_i(clk_i),
      .srst_i(srst_i), .scl(link_if.scl), .m_sda_o(link_if.m_sda_o),
      .m_sda_oe(link_if.m_sda_oe), .d_sda_o(link_if.d_sda_o),
      .d_sda_oe(link_if.d_sda_oe), .sda(link_if.sda));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results();
      if (fail_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   // One host request, held for a single accepting edge
   task automatic do_req(input sre_pkg::sre_op_type op,
      input logic [6:0] a, input logic [7:0] d, input logic [7:0] n);
      @(negedge clk_i);
      while (req_ready_o !== 1'b1) @(negedge clk_i);
      req_op_i = op;
      req_addr_i = a;
      req_data_i = d;
      req_len_i = n;
      req_valid_i = 1'b1;
      @(negedge clk_i);
      req_valid_i = 1'b0;
      repeat (600) @(negedge clk_i);
      check({7'h00, busy_o}, 8'h01);
      while (done_o !== 1'b1) @(negedge clk_i);
      check({7'h00, err_o}, 8'h00);
   endtask : do_req

   // Next received byte against its expected value
   task automatic exp_rx(input logic [7:0] e);
      if (rxq.size() == 0) begin
         check(8'hxx, e);
      end else begin
         check(rxq.pop_front(), e);
      end
   endtask : exp_rx

   // Read byte capture and hang limit
   always @(posedge clk_i) begin
      if (rd_valid_o === 1'b1) begin
         rxq.push_back(rd_data_o);
      end
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         results();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (64) @(negedge clk_i);
      srst_i = 1'b0;
      // Writes, the second one wrapping the pointer
      do_req(sre_pkg::OP_WR, 7'h00, 8'h3c, 8'h01);
      do_req(sre_pkg::OP_WR, 7'h7f, 8'ha5, 8'h01);
      // Pointer read after the write at the top
      do_req(sre_pkg::OP_CUR, 7'h00, 8'h00, 8'h01);
      exp_rx(8'h3c);
      // Chosen location, then a second word across the wrap
      do_req(sre_pkg::OP_RAND, 7'h7f, 8'h00, 8'h02);
      exp_rx(8'ha5);
      exp_rx(8'h3c);
      // Low supply blocks the array write
      @(negedge clk_i);
      supply_ok_i = 1'b0;
      repeat (20) @(negedge clk_i);
      check({7'h00, inhibit_o}, 8'h01);
      do_req(sre_pkg::OP_WR, 7'h00, 8'h99, 8'h01);
      supply_ok_i = 1'b1;
      repeat (20) @(negedge clk_i);
      check({7'h00, inhibit_o}, 8'h00);
      do_req(sre_pkg::OP_RAND, 7'h00, 8'h00, 8'h01);
      exp_rx(8'h3c);
      check(8'(rxq.size()), 8'h00);
      results();
   end
endmodule : serial_eeprom_read_engine_test
